// >>> shared/timer_pkg.sv
// package: register map, field positions and carrier types of the timer
package timer_pkg;
	// register byte addresses on the bus
	localparam logic [7:0] ctrl_off = 8'h00;
	localparam logic [7:0] count_low_off = 8'h04;
	localparam logic [7:0] count_high_off = 8'h08;
	localparam logic [7:0] irq_status_off = 8'h0C;
	localparam logic [7:0] irq_mask_off = 8'h10;
	localparam logic [7:0] port_off = 8'h14;
	// control field positions
	localparam int run_bit = 0;
	localparam int src_bit = 1;
	localparam int sync_bit = 2;
	localparam int osc_bit = 3;
	localparam int ps_lo_bit = 4;
	localparam int wide_bit = 7;
	// reset values, control write mask and count maximum
	localparam logic [7:0] ctrl_reset = 8'h00;
	localparam logic [7:0] ctrl_wmask = 8'hBF;
	localparam logic [15:0] count_reset = 16'h0000;
	localparam logic [15:0] count_max = 16'hFFFF;
	localparam logic [7:0] ps_reset = 8'h00;
	localparam logic [1:0] port_dir_reset = 2'h3;

	typedef struct packed {
		logic wide_access_enable;
		logic unused6;
		logic [1:0] prescale_select;
		logic crystal_osc_enable;
		logic ext_sync_select;
		logic clock_source_select;
		logic count_run_enable;
	} timer_one_control_t;

	typedef struct packed {
		logic wr_low;
		logic wr_high;
		logic rd_low;
		logic [7:0] data;
	} count_access_t;
endpackage

// >>> rtl/edge_sync.sv
// two-stage synchroniser with rising edge detection
`timescale 1ns/1ns
module edge_sync (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// asynchronous level in
	input wire logic async_in,
	// synchronised level and its rising edge
	output logic level,
	output logic rise
);
	logic meta_reg;
	logic sync_reg;
	logic last_reg;

	// first stage read only by the second
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
			last_reg <= 1'b0;
		end else begin
			meta_reg <= async_in;
			sync_reg <= meta_reg;
			last_reg <= sync_reg;
		end
	end

	assign level = sync_reg;
	assign rise = sync_reg & ~last_reg;
endmodule // edge_sync

// >>> rtl/prescaler.sv
// prescaler: passes one tick in 1, 2, 4 or 8
`timescale 1ns/1ns
module prescaler (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// control
	input wire logic clear,
	input wire logic [1:0] select,
	input wire logic tick_in,
	// divided tick
	output logic tick_out
);
	logic [2:0] div_reg;
	logic [2:0] limit;

	// R18: ratio decode
	always_comb begin
		case (select)
			2'h0: limit = 3'h0;
			2'h1: limit = 3'h1;
			2'h2: limit = 3'h3;
			default: limit = 3'h7;
		endcase
	end

	// R15: prescaler clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_reg <= 3'h0;
		end else if (clear) begin
			div_reg <= 3'h0;
		end else if (tick_in) begin
			div_reg <= (div_reg >= limit) ? 3'h0 : div_reg + 3'h1;
		end
	end

	assign tick_out = tick_in & ~clear & (div_reg >= limit);
endmodule // prescaler

// >>> rtl/timer_one.sv
// sixteen-bit timer/counter with AHB-Lite register slave
//
// Overview of operation
// R1: sixteen-bit count held as two byte registers, both readable and writable.
// R2: wrap from FFFF to 0000 signals an overflow event.
// R3: special event trigger from capture/compare unit clears the count.
// R4: count only while run bit 0 is set, else hold.
// R5: modes: internal timer, synchronous counter, asynchronous counter.
// R6: control bit 1 selects the operating mode.
// R7: source select 0 counts once per instruction cycle.
// R8: source select 1 counts rising edges of pin or oscillator.
// R9: control bit 3 starts and stops the crystal oscillator.
// R10: oscillator on forces pins to inputs, ignores direction, reads zero.
// R11: oscillator keeps running while the processor sleeps.
// R12: software waits a start-up delay after enabling the oscillator.
// R13: counter has an internal reset input from the capture/compare unit.
// R14: wide mode: low read latches high byte, low write loads it.
// R15: low byte write clears prescaler; high buffer write does not.
// R16: overflow sets flag bit 0; trigger reset does not.
// R17: software write to the count wins over a coincident trigger.
// R18: prescale bits 5:4 give 1:1, 1:2, 1:4, 1:8.
// R19: sync bit 0 synchronises external clock, 1 leaves it free; the code ignores bit 2 and synchronises both settings.
//
// The AHB-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
module timer_one (
	// bus clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// capture/compare trigger, same clock
	input wire logic special_trigger,
	// processor sleep, same clock
	input wire logic sleep_mode,
	// count clock pins
	input wire logic ext_count_clock_pin,
	input wire logic crystal_in_pin,
	output logic crystal_out_pin,
	output logic crystal_drive_en,
	// port pin direction seen by the port logic
	output logic [1:0] port_dir_effective,
	// interrupt
	output logic irq
);
	timer_pkg::timer_one_control_t ctrl_reg;
	logic [15:0] count_reg;
	logic [7:0] high_buf_reg;
	logic [1:0] port_dir_reg;
	logic status_reg;
	logic mask_reg;
	logic [31:0] rdata_reg;
	logic irq_reg;
	logic osc_out_reg;
	logic drive_reg;
	logic [1:0] dir_out_reg;
	// data phase capture
	logic dp_valid_reg;
	logic dp_write_reg;
	logic [7:0] dp_addr_reg;
	logic ap_take;
	timer_pkg::count_access_t acc;
	logic ext_level;
	logic ext_rise;
	logic pin_level;
	logic src_tick;
	logic ps_tick;
	logic count_tick;
	logic overflow;
	logic xtal_level;
	logic xtal_rise;
	logic sel_rise;

	assign ap_take = hsel & hready & htrans[1];

	// each pin has its own synchroniser, so a source switch makes no edge
	edge_sync i_edge_sync (
		.hclk(hclk),
		.hresetn(hresetn),
		.async_in(ext_count_clock_pin),
		.level(ext_level),
		.rise(ext_rise)
	);

	edge_sync i_edge_sync_xtal (
		.hclk(hclk),
		.hresetn(hresetn),
		.async_in(crystal_in_pin),
		.level(xtal_level),
		.rise(xtal_rise)
	);

	// R10: oscillator pin is the count input when enabled
	assign sel_rise = ctrl_reg.crystal_osc_enable ? xtal_rise : ext_rise;
	// R19: both settings sample through the synchroniser
	assign pin_level = ctrl_reg.crystal_osc_enable ? xtal_level : ext_level;

	// R5: mode selects tick source
	always_comb begin
		// R7: internal clock ticks
		if (!ctrl_reg.clock_source_select) begin
			src_tick = 1'b1;
		// R8: external rising edges
		end else begin
			src_tick = sel_rise & pin_level;
		end
	end

	prescaler i_prescaler (
		.hclk(hclk),
		.hresetn(hresetn),
		.clear(acc.wr_low),
		.select(ctrl_reg.prescale_select),
		.tick_in(src_tick & ctrl_reg.count_run_enable),
		.tick_out(ps_tick)
	);

	// R4: run bit gates counting
	assign count_tick = ps_tick & ctrl_reg.count_run_enable;
	// R2: wrap detection
	// R16: a write or trigger in the same cycle replaces the wrap
	assign overflow = count_tick & (count_reg == timer_pkg::count_max)
		& ~acc.wr_low & ~acc.wr_high & ~special_trigger;

	// bus address phase capture, zero wait states
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_valid_reg <= 1'b0;
			dp_write_reg <= 1'b0;
			dp_addr_reg <= 8'h00;
		end else if (hready) begin
			dp_valid_reg <= ap_take;
			dp_write_reg <= hwrite;
			dp_addr_reg <= haddr;
		end
	end

	always_comb begin
		acc.wr_low = dp_valid_reg & dp_write_reg
			& (dp_addr_reg == timer_pkg::count_low_off);
		acc.wr_high = dp_valid_reg & dp_write_reg
			& (dp_addr_reg == timer_pkg::count_high_off);
		acc.rd_low = ap_take & ~hwrite
			& (haddr == timer_pkg::count_low_off);
		acc.data = hwdata[7:0];
	end

	// R6: control register, R9 oscillator enable inside
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_reg <= timer_pkg::ctrl_reset;
		end else if (dp_valid_reg & dp_write_reg
			& (dp_addr_reg == timer_pkg::ctrl_off)) begin
			ctrl_reg <= hwdata[7:0] & timer_pkg::ctrl_wmask;
		end
	end

	// R1: count register with R13 internal reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count_reg <= timer_pkg::count_reset;
		// R17: write beats trigger
		end else if (acc.wr_low | acc.wr_high) begin
			if (acc.wr_low) begin
				count_reg[7:0] <= acc.data;
			end
			// R14: wide write loads high from buffer
			if (acc.wr_low & ctrl_reg.wide_access_enable) begin
				count_reg[15:8] <= high_buf_reg;
			end else if (acc.wr_high & ~ctrl_reg.wide_access_enable) begin
				count_reg[15:8] <= acc.data;
			end
		// R3: trigger clears count
		end else if (special_trigger) begin
			count_reg <= timer_pkg::count_reset;
		end else if (count_tick) begin
			count_reg <= count_reg + 16'h0001;
		end
	end

	// R14: high byte buffer latched on low read
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			high_buf_reg <= 8'h00;
		end else if (acc.wr_high) begin
			high_buf_reg <= acc.data;
		end else if (acc.rd_low & ctrl_reg.wide_access_enable) begin
			high_buf_reg <= count_reg[15:8];
		end
	end

	// R16: overflow flag, set wins over write-one clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			status_reg <= 1'b0;
			mask_reg <= 1'b0;
			port_dir_reg <= timer_pkg::port_dir_reset;
		end else begin
			if (overflow) begin
				status_reg <= 1'b1;
			end else if (dp_valid_reg & dp_write_reg & hwdata[0]
				& (dp_addr_reg == timer_pkg::irq_status_off)) begin
				status_reg <= 1'b0;
			end
			if (dp_valid_reg & dp_write_reg
				& (dp_addr_reg == timer_pkg::irq_mask_off)) begin
				mask_reg <= hwdata[0];
			end
			if (dp_valid_reg & dp_write_reg
				& (dp_addr_reg == timer_pkg::port_off)) begin
				port_dir_reg <= hwdata[1:0];
			end
		end
	end

	// read data prepared in the address phase, so it stands registered
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rdata_reg <= 32'h00000000;
		end else if (ap_take & ~hwrite) begin
			case (haddr)
				timer_pkg::ctrl_off: rdata_reg <= {24'h000000, ctrl_reg};
				timer_pkg::count_low_off:
					rdata_reg <= {24'h000000, count_reg[7:0]};
				timer_pkg::count_high_off:
					rdata_reg <= {24'h000000, ctrl_reg.wide_access_enable
						? high_buf_reg : count_reg[15:8]};
				timer_pkg::irq_status_off:
					rdata_reg <= {31'h00000000, status_reg};
				timer_pkg::irq_mask_off:
					rdata_reg <= {31'h00000000, mask_reg};
				// R10: pins read as zero while oscillator runs
				timer_pkg::port_off:
					rdata_reg <= {28'h0000000,
						ctrl_reg.crystal_osc_enable ? 2'h0
						: {ext_level, xtal_level},
						port_dir_reg};
				default: rdata_reg <= 32'h00000000;
			endcase
		end
	end

	// pin and interrupt outputs, all registered
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_reg <= 1'b0;
			osc_out_reg <= 1'b0;
			drive_reg <= 1'b0;
			dir_out_reg <= timer_pkg::port_dir_reset;
		end else begin
			irq_reg <= status_reg & mask_reg;
			// R9: amplifier runs only when enabled
			// R11: sleep does not gate the oscillator
			osc_out_reg <= ctrl_reg.crystal_osc_enable & ~xtal_level;
			drive_reg <= ctrl_reg.crystal_osc_enable;
			// R10: direction forced to input
			dir_out_reg <= ctrl_reg.crystal_osc_enable ? 2'h3
				: port_dir_reg;
		end
	end

	assign hrdata = rdata_reg;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign irq = irq_reg;
	assign crystal_out_pin = osc_out_reg;
	assign crystal_drive_en = drive_reg;
	assign port_dir_effective = dir_out_reg;
endmodule // timer_one

// >>> tb/timer_one_asserts.sv
// checker: port-level properties of the timer
`timescale 1ns/1ns
module timer_one_asserts (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// bus
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	// pins and status
	input wire logic sleep_mode,
	input wire logic crystal_in_pin,
	input wire logic crystal_out_pin,
	input wire logic crystal_drive_en,
	input wire logic [1:0] port_dir_effective,
	input wire logic irq
);
	logic [2:0] wr_hist;
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// a recent write is the only excuse for a control or flag change
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			wr_hist <= 3'h0;
		else
			wr_hist <= {wr_hist[1:0], hsel & hready & htrans[1] & hwrite};
	end
	sequence s_rd;
		hsel && hready && htrans[1] && !hwrite;
	endsequence
	AST_OSC_OFF: assert property (!crystal_drive_en |-> !crystal_out_pin)
		else $error("crystal output active while oscillator off");
	AST_OSC_INV: assert property (crystal_drive_en |->
		crystal_out_pin == !$past(crystal_in_pin, 3))
		else $error("crystal output not inverse of input");
	AST_PINS_IN: assert property (crystal_drive_en |->
		port_dir_effective == 2'h3)
		else $error("oscillator pins not forced to inputs");
	AST_PIN_READ: assert property (s_rd ##0 haddr == timer_pkg::port_off
		&& crystal_drive_en ##1 crystal_drive_en |-> hrdata[3:2] == 2'h0)
		else $error("pin levels visible while oscillator on");
	AST_SLEEP_RUN: assert property (sleep_mode && crystal_drive_en
		&& wr_hist == 3'h0 |=> crystal_drive_en)
		else $error("oscillator stopped during sleep");
	AST_UNMAPPED: assert property (s_rd ##0 haddr > timer_pkg::port_off
		|=> hrdata == 32'h0)
		else $error("unmapped read not zero");
	AST_CTRL_READ: assert property (s_rd ##0 haddr == timer_pkg::ctrl_off
		|=> hrdata[31:8] == 24'h0 && !hrdata[6])
		else $error("control read shows unused bits");
	AST_IRQ_FALL: assert property ($fell(irq) |-> wr_hist != 3'h0)
		else $error("interrupt dropped without a write");
endmodule // timer_one_asserts
bind timer_one timer_one_asserts i_asserts (.hclk, .hresetn, .hsel, .haddr,
	.htrans, .hwrite, .hready, .hrdata, .sleep_mode, .crystal_in_pin,
	.crystal_out_pin, .crystal_drive_en, .port_dir_effective, .irq);

// >>> tb/count_clock_model.sv
// model: external count clock pin and low-power crystal
`timescale 1ns/1ns
module count_clock_model (
	// amplifier enable from the timer
	input wire logic osc_drive,
	// clock pins
	output logic ext_pin,
	output logic xtal_pin
);
	initial begin
		ext_pin = 1'b0;
		xtal_pin = 1'b0;
	end
	// an undriven crystal does not swing, so its pin then rests low
	task automatic burst(input logic use_xtal, input int n);
		#37;
		repeat (n) begin
			if (use_xtal)
				xtal_pin = osc_drive;
			else
				ext_pin = 1'b1;
			#200;
			ext_pin = 1'b0;
			xtal_pin = 1'b0;
			#200;
		end
	endtask
	// a static level on the counter pin, for reading it back as port data
	task automatic hold_ext(input logic v);
		ext_pin = v;
	endtask
endmodule // count_clock_model

// >>> tb/sixteen_bit_timer_counter_bench.sv
// testbench: bus-driven scenarios for the timer
`timescale 1ns/1ns
module sixteen_bit_timer_counter_bench;
	localparam logic [7:0] ct = timer_pkg::ctrl_off;
	localparam logic [7:0] lo = timer_pkg::count_low_off;
	localparam logic [7:0] hi = timer_pkg::count_high_off;
	localparam logic [7:0] st = timer_pkg::irq_status_off;
	logic hclk, hresetn, hsel, hwrite, hrdy, hresp, special_trigger;
	logic sleep_mode, ext_pin, xtal_pin, xtal_out, xtal_en, irq;
	logic [7:0] haddr;
	logic [1:0] htrans, port_dir;
	logic [2:0] hsize;
	logic [31:0] hwdata, hrdata, rd_val;
	int n_errors = 0, n_compared = 0, cycles = 0;
	timer_one i_timer_one (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hready(hrdy), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hrdy),
		.hresp(hresp), .special_trigger(special_trigger),
		.sleep_mode(sleep_mode), .ext_count_clock_pin(ext_pin),
		.crystal_in_pin(xtal_pin), .crystal_out_pin(xtal_out),
		.crystal_drive_en(xtal_en), .port_dir_effective(port_dir), .irq(irq));
	count_clock_model src (.osc_drive(xtal_en), .ext_pin(ext_pin),
		.xtal_pin(xtal_pin));
	initial begin
		hclk = 1'b0;
		forever #25 hclk = ~hclk;
	end
	always @(posedge hclk) begin
		cycles++;
		if (cycles == 6000) begin
			n_errors++;
			report_and_stop();
		end
	end
	task automatic report_and_stop();
		if (n_errors == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// trigger rides the data phase so it meets the register update
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic trig);
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge hclk); while (hrdy !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		special_trigger <= trig;
		do @(posedge hclk); while (hrdy !== 1'b1);
		rd_val = hrdata;
		special_trigger <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 1'b0);
	endtask
	task automatic rd(input logic [7:0] a);
		bus(1'b0, a, 32'h0, 1'b0);
	endtask
	initial begin
		{hresetn, hwrite, special_trigger, sleep_mode} = 4'h0;
		{hsel, hsize, htrans, haddr, hwdata} = {1'b1, 3'h2, 42'h0};
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd(ct);
		chk(rd_val, 32'h0);
		chk({hrdy, hresp}, 32'h2);
		rd(8'h18);
		chk(rd_val, 32'h0);
		wr(hi, 32'hA5);
		wr(lo, 32'h3C);
		rd(lo);
		chk(rd_val, 32'h3C);
		rd(hi);
		chk(rd_val, 32'hA5);
		wr(timer_pkg::port_off, 32'h0);
		wr(ct, 32'hFE);
		rd(ct);
		chk(rd_val, 32'hBE);
		chk({xtal_en, port_dir}, 32'h7);
		wr(ct, 32'h0);
		rd(timer_pkg::port_off);
		chk({xtal_en, port_dir}, 32'h0);
		for (int ps = 0; ps < 4; ps++) begin
			wr(hi, 32'h0);
			wr(lo, 32'h0);
			wr(ct, 32'h1 | (ps << 4));
			repeat (62) @(posedge hclk);
			wr(ct, ps << 4);
			repeat (9) @(posedge hclk);
			rd(lo);
			chk(rd_val, 32'h40 >> ps);
		end
		wr(hi, 32'hFF);
		wr(lo, 32'hFE);
		wr(ct, 32'h1);
		repeat (2) @(posedge hclk);
		wr(ct, 32'h0);
		rd(lo);
		chk(rd_val, 32'h2);
		rd(st);
		chk({irq, rd_val[30:0]}, 32'h1);
		wr(timer_pkg::irq_mask_off, 32'h1);
		repeat (2) @(posedge hclk);
		chk(irq, 1'b1);
		wr(st, 32'h1);
		repeat (2) @(posedge hclk);
		chk(irq, 1'b0);
		bus(1'b0, ct, 32'h0, 1'b1);
		rd(lo);
		chk(rd_val, 32'h0);
		rd(st);
		chk(rd_val, 32'h0);
		wr(hi, 32'hFF);
		wr(lo, 32'hFE);
		wr(ct, 32'h1);
		bus(1'b0, ct, 32'h0, 1'b1);
		wr(ct, 32'h0);
		rd(st);
		chk(rd_val, 32'h0);
		bus(1'b1, lo, 32'h5A, 1'b1);
		rd(lo);
		chk(rd_val, 32'h5A);
		wr(hi, 32'h12);
		wr(lo, 32'h34);
		wr(ct, 32'h80);
		wr(hi, 32'h77);
		rd(lo);
		chk(rd_val, 32'h34);
		rd(hi);
		chk(rd_val, 32'h12);
		wr(hi, 32'h9A);
		wr(lo, 32'hBC);
		wr(ct, 32'h0);
		rd(hi);
		chk(rd_val, 32'h9A);
		for (int s = 0; s < 3; s++) begin
			wr(lo, 32'h0);
			wr(ct, s == 2 ? 32'h0A : 32'h3 | (s << 2));
			repeat (20) @(posedge hclk);
			sleep_mode <= (s == 2);
			wr(ct, s == 2 ? 32'h0B : 32'h3 | (s << 2));
			src.burst(s == 2, 5);
			@(posedge hclk);
			if (s == 2) begin
				src.hold_ext(1'b1);
				repeat (3) @(posedge hclk);
				rd(timer_pkg::port_off);
				chk(rd_val, 32'h0);
			end
			wr(ct, 32'h0);
			rd(lo);
			chk(rd_val, 32'h5);
		end
		rd(timer_pkg::port_off);
		chk(rd_val, 32'h8);
		src.hold_ext(1'b0);
		report_and_stop();
	end
endmodule // sixteen_bit_timer_counter_bench
